// >>> verification/tcb_host_model.sv
// tcb_host_model.sv: host processor on the 8-bit I/O bus, with read and write cycles
// assumes the device drive value and enable come straight from the timer ports
`timescale 1ns/10ps

module tcb_host_model (
  input  wire logic       clk_in,      // core clock
  input  wire logic [7:0] data_out_in, // device drive value
  input  wire logic       data_oe_in,  // device drive enable
  output logic            cs_n_out,    // chip select, active low
  output logic            rd_n_out,    // read strobe, active low
  output logic            wr_n_out,    // write strobe, active low
  output logic      [1:0] sel_out,     // port address
  output wire logic [7:0] bus_out      // bus level at the pins
);
  logic [7:0] drv_reg;
  logic       drv_on;
  logic [7:0] last_reg;

  // no pull on the data bus, so a floating bus shows the inverse of its last level
  assign bus_out = data_oe_in ? data_out_in : (drv_on ? drv_reg : ~last_reg);
  always @(posedge clk_in) if (data_oe_in || drv_on) last_reg <= bus_out;

  initial begin
    {cs_n_out, rd_n_out, wr_n_out} = 3'h7;
    sel_out = 2'h0; drv_on = 1'b0; drv_reg = 8'h00; last_reg = 8'h00;
  end

  // one write: strobe low for one edge, then a high cycle before anything else
  task automatic wr(input logic cs, input logic both, input logic [1:0] sel, input logic [7:0] d);
    @(posedge clk_in); #1;
    cs_n_out = !cs;
    rd_n_out = !both;
    wr_n_out = 1'b0; sel_out = sel; drv_reg = d; drv_on = 1'b1;
    @(posedge clk_in); #1;
    {cs_n_out, rd_n_out, wr_n_out} = 3'h7; drv_on = 1'b0;
    @(posedge clk_in);
  endtask

  // one read: the answer is taken at the second edge while the strobe still stands
  task automatic rd(input logic cs, input logic [1:0] sel, output logic [7:0] d, output logic oe);
    @(posedge clk_in); #1;
    cs_n_out = !cs; rd_n_out = 1'b0; sel_out = sel;
    repeat (2) @(posedge clk_in);
    d = bus_out; oe = data_oe_in;
    #1; {cs_n_out, rd_n_out} = 2'h3;
    @(posedge clk_in);
  endtask
endmodule // tcb_host_model

// >>> verification/tcb_timer_props.sv
// tcb_timer_props.sv: bus-side assertions for the triple counter host port
// assumes it sees only the top-level ports and is attached by the bind below
`timescale 1ns/10ps

module tcb_timer_chk (
  input wire logic       clk_in,               // core clock
  input wire logic       rst_in,               // synchronous reset, active high
  input wire logic       cs_n_in,              // chip select, active low
  input wire logic       rd_n_in,              // read strobe, active low
  input wire logic       wr_n_in,              // write strobe, active low
  input wire logic [1:0] port_select_lines_in, // port address
  input wire logic [7:0] data_out,             // data bus drive value
  input wire logic       data_oe_out           // data bus drive enable
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);

  // a valid counter read: selected, read low, write high, not the control port
  wire rd_act = !cs_n_in && !rd_n_in && wr_n_in && (port_select_lines_in != 2'h3);

  property p_unsel_quiet; cs_n_in |=> !data_oe_out; endproperty
  a_unsel_quiet: assert property (p_unsel_quiet) else $error("bus driven while deselected");
  property p_ctrl_read_quiet; (!cs_n_in && !rd_n_in && wr_n_in && port_select_lines_in == 2'h3) |=> !data_oe_out;
  endproperty
  a_ctrl_read_quiet: assert property (p_ctrl_read_quiet) else $error("control port read drove bus");
  property p_no_ctrl_drive; data_oe_out |-> $past(port_select_lines_in) != 2'h3; endproperty
  a_no_ctrl_drive: assert property (p_no_ctrl_drive) else $error("control word put on bus");
  property p_read_drives; rd_act |=> data_oe_out; endproperty
  a_read_drives: assert property (p_read_drives) else $error("read not answered");
  property p_write_quiet; (!cs_n_in && !wr_n_in) |=> !data_oe_out; endproperty
  a_write_quiet: assert property (p_write_quiet) else $error("bus driven during write");
  property p_drive_only_read; data_oe_out |-> $past(rd_act); endproperty
  a_drive_only_read: assert property (p_drive_only_read) else $error("bus driven outside a read");
  property p_release; rd_act ##1 !rd_act |=> !data_oe_out; endproperty
  a_release: assert property (p_release) else $error("bus not released after read");
  property p_idle_zero; !data_oe_out |-> data_out == 8'h00; endproperty
  a_idle_zero: assert property (p_idle_zero) else $error("drive value not cleared");
  property p_both_low; (!cs_n_in && !rd_n_in && !wr_n_in) |=> !data_oe_out; endproperty
  a_both_low: assert property (p_both_low) else $error("both strobes low drove bus");
endmodule // tcb_timer_chk

bind tcb_timer tcb_timer_chk u_chk (
  .clk_in(clk_in), .rst_in(rst_in), .cs_n_in(cs_n_in), .rd_n_in(rd_n_in), .wr_n_in(wr_n_in),
  .port_select_lines_in(port_select_lines_in), .data_out(data_out), .data_oe_out(data_oe_out)
);

// >>> verification/testbench.sv
// testbench.sv: self-checking bench for the triple counter host port and counters
// assumes the host model makes every bus cycle; counter pins are driven here
`timescale 1ns/10ps

module testbench;
  logic       clk_in = 1'b0;
  logic       rst_in = 1'b1;
  logic [2:0] cnt_clk_in;
  logic [2:0] cnt_gate_in;
  wire        cs_n, rd_n, wr_n, doe;
  wire  [1:0] sel;
  wire  [7:0] bus, dout;
  wire  [2:0] wave;
  integer     miscompares = 0;
  integer     compares = 0;
  integer     cycles = 0;
  logic [7:0] b0, b1;
  logic       oe;
  logic [15:0] v;
  logic [1:0] n;

  always #2 clk_in = ~clk_in;

  tcb_timer DUT (.clk_in(clk_in), .rst_in(rst_in), .cs_n_in(cs_n), .rd_n_in(rd_n), .wr_n_in(wr_n),
    .port_select_lines_in(sel), .data_in(bus), .data_out(dout), .data_oe_out(doe),
    .cnt_clk_in(cnt_clk_in), .cnt_gate_in(cnt_gate_in), .cnt_wave_out(wave));
  tcb_host_model host (.clk_in(clk_in), .data_out_in(dout), .data_oe_in(doe), .cs_n_out(cs_n),
    .rd_n_out(rd_n), .wr_n_out(wr_n), .sel_out(sel), .bus_out(bus));

  task wrap_up;
    if (miscompares == 0 && compares > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // two reads of one counter port, low byte first
  task rd16(input logic [1:0] p, output logic [15:0] r);
    host.rd(1'b1, p, b0, oe);
    host.rd(1'b1, p, b1, oe);
    r = {b1, b0};
  endtask

  // counter clock pulses slow enough for the sampled falling edge, then settle
  task tick(input logic [2:0] which, input integer k);
    repeat (k) begin
      @(posedge clk_in); #1 cnt_clk_in = which;
      repeat (3) @(posedge clk_in);
      #1 cnt_clk_in = 3'h0;
      repeat (3) @(posedge clk_in);
    end
    repeat (4) @(posedge clk_in);
  endtask

  // hang guard, far above the few hundred cycles the sequence needs
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      wrap_up;
    end
  end

  initial begin
    cnt_clk_in = 3'h0; cnt_gate_in = 3'h0;
    repeat (6) @(posedge clk_in);
    #1 rst_in = 1'b0;
    // gates low hold mode 0 counts, so loaded values read back exactly
    for (n = 2'h0; n != 2'h3; n++) begin
      host.wr(1'b1, 1'b0, 2'h3, {n, 2'h3, 4'h0});
      host.wr(1'b1, 1'b0, n, {6'h04, n});
      host.wr(1'b1, 1'b0, n, {6'h28, n});
    end
    for (n = 2'h0; n != 2'h3; n++) begin
      rd16(n, v);
      chk(v, {6'h28, n, 6'h04, n});
    end
    host.rd(1'b1, 2'h3, b0, oe);
    chk({15'h0, oe}, 16'h0000);
    host.wr(1'b0, 1'b0, 2'h0, 8'h55);
    host.wr(1'b0, 1'b0, 2'h0, 8'h66);
    host.rd(1'b0, 2'h0, b0, oe);
    chk({15'h0, oe}, 16'h0000);
    rd16(2'h0, v);
    chk(v, 16'hA010);
    host.wr(1'b1, 1'b1, 2'h1, 8'h77);
    rd16(2'h1, v);
    chk(v, 16'hA111);
    // single-byte access: low only on counter 1, high only on counter 2
    host.wr(1'b1, 1'b0, 2'h3, 8'h50);
    host.wr(1'b1, 1'b0, 2'h1, 8'h5A);
    rd16(2'h1, v);
    chk(v, 16'h5A5A);
    host.wr(1'b1, 1'b0, 2'h3, 8'hA0);
    host.wr(1'b1, 1'b0, 2'h2, 8'hA5);
    host.rd(1'b1, 2'h2, b0, oe);
    chk({8'h00, b0}, 16'h00A5);
    rd16(2'h0, v);
    chk(v, 16'hA010);
    // counter 0 runs in mode 0 from 3; ticks come with the host deselected
    host.wr(1'b1, 1'b0, 2'h3, 8'h30);
    host.wr(1'b1, 1'b0, 2'h0, 8'h03);
    host.wr(1'b1, 1'b0, 2'h0, 8'h00);
    #1 cnt_gate_in = 3'h1;
    chk({15'h0, wave[0]}, 16'h0000);
    tick(3'h1, 1);
    host.wr(1'b1, 1'b0, 2'h3, 8'h00);
    tick(3'h1, 1);
    rd16(2'h0, v);
    chk(v, 16'h0002);
    rd16(2'h0, v);
    chk(v, 16'h0001);
    tick(3'h1, 1);
    chk({15'h0, wave[0]}, 16'h0001);
    // counter 1 counts BCD, counter 2 is a rate generator; gates rise before arming
    #1 cnt_gate_in = 3'h7;
    host.wr(1'b1, 1'b0, 2'h3, 8'h51);
    host.wr(1'b1, 1'b0, 2'h1, 8'h10);
    host.wr(1'b1, 1'b0, 2'h3, 8'h94);
    chk({15'h0, wave[2]}, 16'h0001);
    host.wr(1'b1, 1'b0, 2'h2, 8'h03);
    tick(3'h6, 1);
    rd16(2'h1, v);
    chk(v, 16'h0909);
    chk({15'h0, wave[2]}, 16'h0001);
    tick(3'h6, 1);
    chk({14'h0, wave[2:1]}, 16'h0000);
    tick(3'h4, 1);
    chk({15'h0, wave[2]}, 16'h0001);
    rd16(2'h2, v);
    chk(v, 16'h0303);
    wrap_up;
  end
endmodule // testbench

// >>> verilog/tcb_byte_port.v
// tcb_byte_port.v: byte sequencing of one counter port (load, latch and read order)
// assumes one-cycle pulses for each write, latch command and completed read
`timescale 1ns/10ps
`include "tcb_consts.vh"

module tcb_byte_port (
  input  wire        clk_in,      // core clock
  input  wire        rst_in,      // synchronous reset, active high
  input  wire        cfg_in,      // control word with nonzero byte access field
  input  wire [1:0]  rl_in,       // byte access field of that word
  input  wire        latch_in,    // counter latch command
  input  wire        wr_in,       // write pulse to this counter port
  input  wire [7:0]  data_in,     // written byte
  input  wire        rd_done_in,  // a read of this port has ended
  input  wire [15:0] live_in,     // running count
  output reg         load_out,    // one-cycle load of a full count
  output reg  [15:0] value_out,   // count to load
  output wire [7:0]  rd_byte_out  // byte the next read returns
);

  reg [1:0]  rl_reg;
  reg        wr_hi_reg;
  reg        rd_hi_reg;
  reg [7:0]  lsb_reg;
  reg        latched_reg;
  reg [15:0] hold_reg;

  // a latched value wins over the live count until it has been read out
  wire [15:0] src = latched_reg ? hold_reg : live_in;
  wire        hi  = (rl_reg == `TCB_RL_MSB) | ((rl_reg == `TCB_RL_BOTH) & rd_hi_reg);
  assign rd_byte_out = hi ? src[15:8] : src[7:0];

  // write order, read order and latch per byte access field
  always @(posedge clk_in) begin
    load_out <= 1'b0;
    if (rst_in) begin
      rl_reg      <= `TCB_RL_RST;
      wr_hi_reg   <= 1'b0;
      rd_hi_reg   <= 1'b0;
      lsb_reg     <= 8'h00;
      latched_reg <= 1'b0;
      hold_reg    <= `TCB_CNT_RST;
      value_out   <= `TCB_CNT_RST;
    end else begin
      if (cfg_in) begin
        rl_reg      <= rl_in;
        wr_hi_reg   <= 1'b0;
        rd_hi_reg   <= 1'b0;
        latched_reg <= 1'b0;
      end else if (wr_in) begin
        case (rl_reg)
          `TCB_RL_LSB: begin
            value_out <= {8'h00, data_in};
            load_out  <= 1'b1;
          end
          `TCB_RL_MSB: begin
            value_out <= {data_in, 8'h00};
            load_out  <= 1'b1;
          end
          default: begin
            if (wr_hi_reg) begin
              value_out <= {data_in, lsb_reg};
              load_out  <= 1'b1;
            end else begin
              lsb_reg <= data_in;
            end
            wr_hi_reg <= ~wr_hi_reg;
          end
        endcase
      end
      if (rd_done_in) begin
        if (rl_reg == `TCB_RL_BOTH)
          rd_hi_reg <= ~rd_hi_reg;
        if ((rl_reg != `TCB_RL_BOTH) | rd_hi_reg)
          latched_reg <= 1'b0;
      end
      // a second latch before the first is read is ignored
      if (latch_in & ~latched_reg) begin
        hold_reg    <= live_in;
        latched_reg <= 1'b1;
      end
    end
  end

endmodule // tcb_byte_port

// >>> verilog/tcb_consts.vh
// tcb_consts.vh: register offsets, control word fields and reset values of the triple counter
// assumes it is included by bare name into every design file of the block
`ifndef TCB_CONSTS_VH
`define TCB_CONSTS_VH

// port offsets seen on the two select lines
`define TCB_PORT_CNT0   2'h0
`define TCB_PORT_CNT1   2'h1
`define TCB_PORT_CNT2   2'h2
`define TCB_PORT_CTRL   2'h3

// control word field positions
`define TCB_SC_HI       7
`define TCB_SC_LO       6
`define TCB_RL_HI       5
`define TCB_RL_LO       4
`define TCB_MODE_HI     3
`define TCB_MODE_LO     1
`define TCB_BCD_BIT     0

// byte access field codes
`define TCB_RL_LATCH    2'h0
`define TCB_RL_LSB      2'h1
`define TCB_RL_MSB      2'h2
`define TCB_RL_BOTH     2'h3

// counting modes after folding codes 6 and 7 onto 2 and 3
`define TCB_MODE_INT    3'h0
`define TCB_MODE_SHOT   3'h1
`define TCB_MODE_RATE   3'h2
`define TCB_MODE_SQR    3'h3
`define TCB_MODE_SSTB   3'h4
`define TCB_MODE_HSTB   3'h5

// reset values
`define TCB_CTRL_RST    8'h00
`define TCB_CNT_RST     16'h0000
`define TCB_RL_RST      2'h3

`endif

// >>> verilog/tcb_down_counter.v
// tcb_down_counter.v: one 16-bit presettable down counter with six modes
// assumes tick and trigger are one-cycle pulses from sampled counter pins
`timescale 1ns/10ps
`include "tcb_consts.vh"

module tcb_down_counter (
  input  wire        clk_in,    // core clock
  input  wire        rst_in,    // synchronous reset, active high
  input  wire        arm_in,    // new control word for this counter
  input  wire [2:0]  mode_in,   // folded counting mode
  input  wire        bcd_in,    // count in BCD
  input  wire        load_in,   // full count loaded
  input  wire [15:0] value_in,  // loaded count
  input  wire        tick_in,   // counter clock falling edge
  input  wire        gate_in,   // gate level
  input  wire        trig_in,   // gate rising edge
  output wire [15:0] count_out, // live count
  output wire        wave_out   // counter output
);

  reg [15:0] cnt_reg;
  reg [15:0] preset_reg;
  reg        out_reg;
  reg        run_reg;
  reg        pend_reg;
  reg        have_reg;

  // one step down in binary or BCD; zero wraps to the top so 0 means max count
  function [15:0] step_down;
    input [15:0] v;
    input        b;
    reg   [15:0] r;
    reg          brw;
    integer      k;
    begin
      r   = v;
      brw = 1'b1;
      if (b) begin
        for (k = 0; k < 4; k = k + 1) begin
          if (brw) begin
            if (r[k*4 +: 4] == 4'h0) begin
              r[k*4 +: 4] = 4'h9;
            end else begin
              r[k*4 +: 4] = r[k*4 +: 4] - 4'h1;
              brw         = 1'b0;
            end
          end
        end
      end else begin
        r = v - 16'h0001;
      end
      step_down = r;
    end
  endfunction

  wire [15:0] dec1 = step_down(cnt_reg, bcd_in);
  wire [15:0] dec2 = step_down(dec1, bcd_in);
  wire        tc   = (cnt_reg == 16'h0001);

  assign count_out = cnt_reg;
  assign wave_out  = out_reg;

  // counting per mode; gate edges are held pending until the next tick
  always @(posedge clk_in) begin
    if (rst_in) begin
      cnt_reg    <= `TCB_CNT_RST;
      preset_reg <= `TCB_CNT_RST;
      out_reg    <= 1'b0;
      run_reg    <= 1'b0;
      pend_reg   <= 1'b0;
      have_reg   <= 1'b0;
    end else begin
      if (arm_in) begin
        run_reg  <= 1'b0;
        pend_reg <= 1'b0;
        have_reg <= 1'b0;
        out_reg  <= (mode_in != `TCB_MODE_INT);
      end else if (load_in) begin
        preset_reg <= value_in;
        have_reg   <= 1'b1;
        case (mode_in)
          `TCB_MODE_INT, `TCB_MODE_SSTB: begin
            cnt_reg <= value_in;
            run_reg <= 1'b1;
            out_reg <= (mode_in != `TCB_MODE_INT);
          end
          `TCB_MODE_RATE, `TCB_MODE_SQR: begin
            if (!run_reg) begin
              cnt_reg <= value_in;
              run_reg <= 1'b1;
            end
          end
          default: ;
        endcase
      end else if (tick_in) begin
        case (mode_in)
          `TCB_MODE_INT: begin
            if (run_reg & gate_in) begin
              cnt_reg <= dec1;
              if (tc)
                out_reg <= 1'b1;
            end
          end
          `TCB_MODE_SSTB: begin
            if (run_reg & gate_in) begin
              cnt_reg <= dec1;
              out_reg <= ~tc;
              if (tc)
                run_reg <= 1'b0;
            end else begin
              out_reg <= 1'b1;
            end
          end
          `TCB_MODE_SHOT, `TCB_MODE_HSTB: begin
            if (pend_reg & have_reg) begin
              pend_reg <= 1'b0;
              cnt_reg  <= preset_reg;
              run_reg  <= 1'b1;
              out_reg  <= (mode_in != `TCB_MODE_SHOT);
            end else if (run_reg) begin
              cnt_reg <= dec1;
              out_reg <= (mode_in == `TCB_MODE_SHOT) ? tc : ~tc;
              if (tc)
                run_reg <= 1'b0;
            end else begin
              out_reg <= 1'b1;
            end
          end
          `TCB_MODE_RATE: begin
            if (!gate_in) begin
              out_reg <= 1'b1;
            end else if (run_reg) begin
              if (pend_reg | tc) begin
                pend_reg <= 1'b0;
                cnt_reg  <= preset_reg;
                out_reg  <= 1'b1;
              end else begin
                cnt_reg <= dec1;
                out_reg <= (dec1 != 16'h0001);
              end
            end
          end
          default: begin
            if (!gate_in) begin
              out_reg <= 1'b1;
            end else if (run_reg) begin
              if (pend_reg | tc | (cnt_reg == 16'h0002)) begin
                pend_reg <= 1'b0;
                cnt_reg  <= {preset_reg[15:1], 1'b0};
                out_reg  <= pend_reg | ~out_reg;
              end else begin
                cnt_reg <= dec2;
              end
            end
          end
        endcase
      end
      // set wins over any clear above in the same cycle
      if (trig_in)
        pend_reg <= 1'b1;
    end
  end

endmodule // tcb_down_counter

// >>> verilog/tcb_timer.v
// tcb_timer.v: three 16-bit down counters behind an 8-bit host port
// assumes host strobes and counter pins are synchronous to clk_in
// counter clocks are sampled, so each must stay below half of clk_in
`timescale 1ns/10ps
`include "tcb_consts.vh"

module tcb_timer (
  input  wire       clk_in,                 // core clock, 250 MHz
  input  wire       rst_in,                 // synchronous reset, active high
  input  wire       cs_n_in,                // chip select, active low
  input  wire       rd_n_in,                // read strobe, active low
  input  wire       wr_n_in,                // write strobe, active low
  input  wire [1:0] port_select_lines_in,   // port address
  input  wire [7:0] data_in,                // data bus as seen at the pins
  output reg  [7:0] data_out,               // data bus drive value
  output reg        data_oe_out,            // data bus drive enable, high drives
  input  wire [2:0] cnt_clk_in,             // counter clock pins, one per counter
  input  wire [2:0] cnt_gate_in,            // counter gate pins, one per counter
  output wire [2:0] cnt_wave_out            // counter output pins, one per counter
);

  // decoding used for writes, reads and control word targets alike
  function port_hit;
    input [1:0] port;
    input [1:0] idx;
    begin
      port_hit = (port == idx);
    end
  endfunction

  // mode code 6 and 7 act as 2 and 3
  function [2:0] fold_mode;
    input [2:0] m;
    begin
      if (m[1])
        fold_mode = {1'b0, m[1:0]};
      else
        fold_mode = m;
    end
  endfunction

  reg        wr_prev_reg;
  reg        rd_prev_reg;
  reg [1:0]  rd_port_reg;
  reg [7:0]  control_word_reg;
  reg [2:0]  cclk_prev_reg;
  reg [2:0]  gate_prev_reg;

  wire [23:0] rd_bytes;
  wire [7:0]  rd_sel_byte;

  // strobe qualification: nothing happens unless chip select is low
  wire sel     = ~cs_n_in;
  wire both    = ~rd_n_in & ~wr_n_in;
  wire wr_act  = sel & ~wr_n_in & ~both;
  wire rd_ctrl = port_hit(port_select_lines_in, `TCB_PORT_CTRL);
  // read at the control port is a no-operation and keeps the bus released
  wire rd_act  = sel & ~rd_n_in & ~both & ~rd_ctrl;

  // one action per write strobe, taken on its first low cycle
  wire wr_pulse = wr_act & ~wr_prev_reg;
  // byte sequencing steps when a read ends, so a long strobe sees one byte
  wire rd_done  = rd_prev_reg & ~rd_act;

  wire       ctrl_wr = wr_pulse & port_hit(port_select_lines_in, `TCB_PORT_CTRL);
  wire [1:0] cw_sc   = data_in[`TCB_SC_HI:`TCB_SC_LO];
  wire [1:0] cw_rl   = data_in[`TCB_RL_HI:`TCB_RL_LO];
  wire [2:0] cw_mode = data_in[`TCB_MODE_HI:`TCB_MODE_LO];
  wire       cw_bcd  = data_in[`TCB_BCD_BIT];

  // counter pin edges: falling clock counts, rising gate triggers
  wire [2:0] cclk_fall = cclk_prev_reg & ~cnt_clk_in;
  wire [2:0] gate_rise = cnt_gate_in & ~gate_prev_reg;

  // strobe history and pin sampling
  always @(posedge clk_in) begin
    if (rst_in) begin
      wr_prev_reg   <= 1'b0;
      rd_prev_reg   <= 1'b0;
      rd_port_reg   <= `TCB_PORT_CNT0;
      cclk_prev_reg <= 3'h0;
      gate_prev_reg <= 3'h0;
    end else begin
      wr_prev_reg   <= wr_act;
      rd_prev_reg   <= rd_act;
      // cs is not looked at here, so counting never depends on selection
      cclk_prev_reg <= cnt_clk_in;
      gate_prev_reg <= cnt_gate_in;
      if (rd_act)
        rd_port_reg <= port_select_lines_in;
    end
  end

  // write-only control word register, kept for the last write it saw
  always @(posedge clk_in) begin
    if (rst_in)
      control_word_reg <= `TCB_CTRL_RST;
    else if (ctrl_wr)
      control_word_reg <= data_in;
  end

  // the three identical counter channels
  genvar i;
  generate
    for (i = 0; i < 3; i = i + 1) begin : g_ch
      localparam [1:0] CH_IDX = i;
      reg  [2:0]  mode_reg;
      reg         bcd_reg;
      wire [15:0] live;
      wire        load;
      wire [15:0] value;
      wire        tgt    = ctrl_wr & port_hit(cw_sc, CH_IDX);
      wire        cfg    = tgt & (cw_rl != `TCB_RL_LATCH);
      wire        latch  = tgt & (cw_rl == `TCB_RL_LATCH);
      wire        wr_cnt = wr_pulse & port_hit(port_select_lines_in, CH_IDX);
      wire        rd_end = rd_done & port_hit(rd_port_reg, CH_IDX);
      // arming must see the new mode, or the output starts at the old mode's level
      wire [2:0]  mode_now = cfg ? fold_mode(cw_mode) : mode_reg;

      // a latch command leaves mode and BCD untouched
      always @(posedge clk_in) begin
        if (rst_in) begin
          mode_reg <= `TCB_MODE_INT;
          bcd_reg  <= 1'b0;
        end else if (cfg) begin
          mode_reg <= fold_mode(cw_mode);
          bcd_reg  <= cw_bcd;
        end
      end

      tcb_byte_port u_port (
        .clk_in      (clk_in),
        .rst_in      (rst_in),
        .cfg_in      (cfg),
        .rl_in       (cw_rl),
        .latch_in    (latch),
        .wr_in       (wr_cnt),
        .data_in     (data_in),
        .rd_done_in  (rd_end),
        .live_in     (live),
        .load_out    (load),
        .value_out   (value),
        .rd_byte_out (rd_bytes[i*8 +: 8])
      );

      tcb_down_counter u_cnt (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .arm_in    (cfg),
        .mode_in   (mode_now),
        .bcd_in    (bcd_reg),
        .load_in   (load),
        .value_in  (value),
        .tick_in   (cclk_fall[i]),
        .gate_in   (cnt_gate_in[i]),
        .trig_in   (gate_rise[i]),
        .count_out (live),
        .wave_out  (cnt_wave_out[i])
      );
    end
  endgenerate

  // only counter bytes reach the bus; the control word has no read path
  assign rd_sel_byte = port_hit(port_select_lines_in, `TCB_PORT_CNT2) ? rd_bytes[23:16] :
                       port_hit(port_select_lines_in, `TCB_PORT_CNT1) ? rd_bytes[15:8] :
                       rd_bytes[7:0];

  // registered bus drive: one cycle behind the strobe, released the same way
  always @(posedge clk_in) begin
    if (rst_in) begin
      data_out    <= 8'h00;
      data_oe_out <= 1'b0;
    end else begin
      data_oe_out <= rd_act;
      if (rd_act)
        data_out <= rd_sel_byte;
      else
        data_out <= 8'h00;
    end
  end

endmodule // tcb_timer
